// ---- src/ump_pkg.sv ----
/*
 * constants and types shared by the auxiliary serial-port modes block:
 * multidrop address handling, infrared shaping, sleep and loopback.
 * assumes a core receiver/transmitter on the same clock supplies bytes,
 * serial bits and a 16x oversampling tick.
 */
// What this block does
// - multidrop on when multidrop bit, unlock set, special detect off; forces zero parity
// - normal multidrop: parity-one byte is address, flags parity error; data dropped if disabled
// - normal multidrop: every address byte stored in fifo, line status interrupt raised
// - receiver enabled: data bytes accepted, each further address raises line status interrupt
// - auto address detect on when multidrop bit, unlock and special detect all set
// - auto detect compares addresses with second stop char; discards others while disabled
// - matching address enables receiver, stored with parity in error slot, interrupt raised
// - auto detect: mismatching address while enabled disables receiver and is dropped
// - basic infrared: high pulse of 3/16 bit for each zero bit
// - fast infrared: high pulse of 1/4 bit for each zero bit
// - control bit 6 enables infrared; status bit 7 with unlock selects fast
// - infrared receive input idles low from reset
// - sleep only with no interrupt, enable set, no modem deltas, rx idle, divisor, fifos empty
// - sleep stops the oscillator output
// - wake on rx start edge, transmit write or any modem input change
// - after wake, sleep re-entered automatically once interrupts are cleared
// - never sleep with interrupt pending; keep sleeping until enable cleared
// - asleep with isolate pin high: isolate bus inputs
// - isolated: wake only by rx start edge or modem input change
// - back to isolation automatically; leave when enable cleared or pin low
// - wake-up interrupt enabled by fifo control bit 3, disabled after reset
// - loopback feeds transmit shift output into receive input
// - loopback: tx held mark, modem outputs deasserted, modem inputs ignored
package ump_pkg;
   localparam int UMP_DATA_W = 8;
   localparam int UMP_WORD_W = 9;
   localparam int UMP_FIFO_DEPTH = 4;
   localparam int UMP_OVERSAMPLE = 16;
   localparam logic [3:0] UMP_IR_SLOW_TICKS = 4'h3;
   localparam logic [3:0] UMP_IR_FAST_TICKS = 4'h4;
   localparam logic [3:0] UMP_IR_BIT_LAST = 4'hF;
   localparam int UMP_PAR_ERR_POS = 8;
   localparam logic [3:0] UMP_MODEM_IDLE = 4'hF;
   localparam logic UMP_MARK = 1'b1;
   localparam logic UMP_IR_IDLE = 1'b0;
   typedef enum logic [1:0] {
      UMP_AWAKE = 2'b01,
      UMP_ASLEEP = 2'b10
   } ump_pwr_t;
endpackage

// ---- src/ump_fifo.sv ----
/*
 * small synchronous fifo with valid/ready on both sides and a fill level.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module ump_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // status
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [$clog2(DEPTH+1)-1:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];
   assign level = cnt_q;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// ---- src/ump_aux.sv ----
/*
 * auxiliary modes of the serial port: multidrop address filtering into a
 * 4-word receive buffer, infrared pulse encode/decode, sleep with wake-up
 * and bus isolation, wake-up interrupt and internal loopback.
 * assumes the core uart shares ref_clk, hands received bytes with their
 * parity bit, gives its transmit shift output and a 16x bit tick.
 */
`timescale 1ns/1ps
module ump_aux (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // configuration bits
   input wire logic enh_unlock,
   input wire logic spec_char_en,
   input wire logic multidrop_en,
   input wire logic irda_fast_sel,
   input wire logic irda_en,
   input wire logic loopback_en,
   input wire logic sleep_en,
   input wire logic wake_int_en,
   input wire logic [ump_pkg::UMP_DATA_W-1:0] second_stop_char,
   // host receiver enable control
   input wire logic rx_enable_wr,
   input wire logic rx_enable_val,
   // received characters from core
   input wire logic rx_char_valid,
   input wire logic [ump_pkg::UMP_DATA_W-1:0] rx_char_data,
   input wire logic rx_char_parity,
   input wire logic rx_char_perr,
   output logic rx_char_ready,
   // receive buffer drain
   output logic rxb_valid,
   input wire logic rxb_ready,
   output logic [ump_pkg::UMP_WORD_W-1:0] rxb_data,
   // receive status
   output logic rx_enabled,
   output logic force_parity_zero,
   output logic line_status_int,
   // serial path
   input wire logic baud16_tick,
   input wire logic tx_bit_start,
   input wire logic tx_shift_out,
   input wire logic rx_pin,
   output logic tx_pin,
   output logic rx_to_core,
   // modem signals
   input wire logic rts_req,
   input wire logic dtr_req,
   input wire logic cts_n_in,
   input wire logic dsr_n_in,
   input wire logic carrier_detect_in,
   input wire logic ring_indicate_in,
   output logic rts_n_out,
   output logic dtr_n_out,
   output logic [3:0] modem_to_core,
   // sleep conditions
   input wire logic int_pending,
   input wire logic [3:0] msr_delta,
   input wire logic divisor_nonzero,
   input wire logic tx_fifo_empty,
   input wire logic rx_fifo_empty,
   input wire logic thr_write,
   input wire logic bus_isolate_pin,
   input wire logic wake_int_clr,
   // power outputs
   output logic asleep,
   output logic osc_run,
   output logic bus_isolated,
   output logic wake_int
);
   import ump_pkg::*;

   // synchronisers: pins into ref_clk
   logic rx_s1_q, rx_s2_q, rx_s3_q;
   logic [3:0] mdm_s1_q, mdm_s2_q, mdm_s3_q;
   logic iso_s1_q, iso_s2_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rx_s1_q <= UMP_MARK;
         rx_s2_q <= UMP_MARK;
         rx_s3_q <= UMP_MARK;
      end else begin
         rx_s1_q <= rx_pin;
         rx_s2_q <= rx_s1_q;
         rx_s3_q <= rx_s2_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mdm_s1_q <= UMP_MODEM_IDLE;
         mdm_s2_q <= UMP_MODEM_IDLE;
         mdm_s3_q <= UMP_MODEM_IDLE;
         iso_s1_q <= 1'b0;
         iso_s2_q <= 1'b0;
      end else begin
         mdm_s1_q <= {ring_indicate_in, carrier_detect_in, dsr_n_in, cts_n_in};
         mdm_s2_q <= mdm_s1_q;
         mdm_s3_q <= mdm_s2_q;
         iso_s1_q <= bus_isolate_pin;
         iso_s2_q <= iso_s1_q;
      end
   end

   // mode decode
   logic md_normal, md_auto, ir_fast;
   assign md_normal = multidrop_en & enh_unlock & ~spec_char_en;
   assign md_auto = multidrop_en & enh_unlock & spec_char_en;
   assign ir_fast = irda_fast_sel & enh_unlock;

   // multidrop filter
   logic is_addr, addr_match, keep, push_ok;
   logic [UMP_WORD_W-1:0] word;
   logic [$clog2(UMP_FIFO_DEPTH+1)-1:0] level;
   logic fifo_in_ready, fifo_pop, fifo_push;
   logic rx_en_q, lsi_q, rdy_q, fpz_q;

   assign is_addr = rx_char_parity;
   assign addr_match = (rx_char_data == second_stop_char);
   assign push_ok = rx_char_valid & rdy_q;

   always_comb begin
      keep = 1'b1;
      word = {rx_char_perr, rx_char_data};
      if (md_normal) begin
         keep = is_addr | rx_en_q;
         word[UMP_PAR_ERR_POS] = is_addr;
      end else if (md_auto) begin
         keep = is_addr ? addr_match : rx_en_q;
         word[UMP_PAR_ERR_POS] = rx_char_parity;
      end
   end

   assign fifo_push = push_ok & keep & fifo_in_ready;
   assign fifo_pop = rxb_valid & rxb_ready;

   // receiver enable: hardware action wins over a host write in the same cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rx_en_q <= 1'b0;
      end else if (md_auto && push_ok && is_addr) begin
         rx_en_q <= addr_match;
      end else if (rx_enable_wr) begin
         rx_en_q <= rx_enable_val;
      end
   end

   // line status interrupt pulse on each stored address byte
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         lsi_q <= 1'b0;
      end else begin
         lsi_q <= fifo_push & is_addr & (md_normal | md_auto);
      end
   end

   // ready looks one push ahead since it is registered
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rdy_q <= 1'b0;
         fpz_q <= 1'b0;
      end else begin
         rdy_q <= (32'(level) + 32'(fifo_push) - 32'(fifo_pop)) < UMP_FIFO_DEPTH;
         fpz_q <= md_normal | md_auto;
      end
   end

   ump_fifo #(
      .WIDTH(UMP_WORD_W),
      .DEPTH(UMP_FIFO_DEPTH)
   ) u_rxbuf (
      .ref_clk(ref_clk),
      .reset(reset),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(word),
      .out_valid(rxb_valid),
      .out_ready(rxb_ready),
      .out_data(rxb_data),
      .level(level)
   );

   assign rx_char_ready = rdy_q;
   assign rx_enabled = rx_en_q;
   assign force_parity_zero = fpz_q;
   assign line_status_int = lsi_q;

   // infrared encoder: phase within bit, restarted at each bit start
   logic [3:0] ph_q, ir_width;
   logic ir_pulse;
   assign ir_width = ir_fast ? UMP_IR_FAST_TICKS : UMP_IR_SLOW_TICKS;
   assign ir_pulse = ~tx_shift_out & (ph_q < ir_width);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ph_q <= '0;
      end else if (tx_bit_start) begin
         ph_q <= '0;
      end else if (baud16_tick && ph_q != UMP_IR_BIT_LAST) begin
         ph_q <= ph_q + 1'b1;
      end
   end

   // infrared decoder: a light pulse yields a zero for one bit time
   logic [3:0] dec_q;
   logic dec_busy_q, ir_rise;
   assign ir_rise = rx_s2_q & ~rx_s3_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dec_q <= '0;
         dec_busy_q <= 1'b0;
      end else if (ir_rise) begin
         dec_q <= '0;
         dec_busy_q <= 1'b1;
      end else if (dec_busy_q && baud16_tick) begin
         dec_q <= dec_q + 1'b1;
         dec_busy_q <= (dec_q != UMP_IR_BIT_LAST);
      end
   end

   // serial pins and loopback
   logic tx_q, rxc_q, rts_q, dtr_q;
   logic [3:0] mdm_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tx_q <= UMP_MARK;
         rxc_q <= UMP_MARK;
         rts_q <= 1'b1;
         dtr_q <= 1'b1;
         mdm_q <= UMP_MODEM_IDLE;
      end else if (loopback_en) begin
         tx_q <= UMP_MARK;
         rxc_q <= tx_shift_out;
         rts_q <= 1'b1;
         dtr_q <= 1'b1;
         mdm_q <= UMP_MODEM_IDLE;
      end else begin
         tx_q <= irda_en ? ir_pulse : tx_shift_out;
         rxc_q <= irda_en ? ~dec_busy_q : rx_s2_q;
         rts_q <= ~rts_req;
         dtr_q <= ~dtr_req;
         mdm_q <= mdm_s2_q;
      end
   end

   assign tx_pin = tx_q;
   assign rx_to_core = rxc_q;
   assign rts_n_out = rts_q;
   assign dtr_n_out = dtr_q;
   assign modem_to_core = mdm_q;

   // sleep control
   ump_pwr_t pwr_q;
   logic rx_idle, start_edge, mdm_change, wake_ev, can_sleep;
   logic iso_q, osc_q, wint_q;

   // in infrared mode the pin idles low and a start bit is a rising pulse
   assign rx_idle = irda_en ? (rx_s2_q == UMP_IR_IDLE) : rx_s2_q;
   assign start_edge = irda_en ? ir_rise : (rx_s3_q & ~rx_s2_q);
   assign mdm_change = ~loopback_en & (mdm_s2_q != mdm_s3_q);
   assign wake_ev = start_edge | mdm_change | (thr_write & ~iso_q);
   assign can_sleep = ~int_pending & ~wint_q & sleep_en & (msr_delta == 4'h0)
                      & rx_idle & divisor_nonzero & tx_fifo_empty & rx_fifo_empty
                      & ~rxb_valid & ~wake_ev;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pwr_q <= UMP_AWAKE;
      end else begin
         case (pwr_q)
            UMP_AWAKE: begin
               if (can_sleep) begin
                  pwr_q <= UMP_ASLEEP;
               end
            end
            UMP_ASLEEP: begin
               if (wake_ev || !sleep_en) begin
                  pwr_q <= UMP_AWAKE;
               end
            end
            default: begin
               pwr_q <= UMP_AWAKE;
            end
         endcase
      end
   end

   // isolation follows sleep; leaves three cycles after the pin drops, or on a wake event
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         iso_q <= 1'b0;
         osc_q <= 1'b1;
      end else begin
         iso_q <= (pwr_q == UMP_ASLEEP) & iso_s2_q & sleep_en & ~wake_ev;
         osc_q <= (pwr_q != UMP_ASLEEP) | wake_ev | ~sleep_en;
      end
   end

   // wake-up interrupt: set wins over the host clear
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wint_q <= 1'b0;
      end else if (pwr_q == UMP_ASLEEP && wake_ev && wake_int_en) begin
         wint_q <= 1'b1;
      end else if (wake_int_clr) begin
         wint_q <= 1'b0;
      end
   end

   logic sleep_q;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sleep_q <= 1'b0;
      end else begin
         sleep_q <= (pwr_q == UMP_ASLEEP) & ~wake_ev & sleep_en;
      end
   end

   assign asleep = sleep_q;
   assign osc_run = osc_q;
   assign bus_isolated = iso_q;
   assign wake_int = wint_q;
endmodule

// ---- sim/ump_aux_monitor.sv ----
/*
 * assertions on the ports of the auxiliary serial-port modes block.
 * assumes a single ref_clk domain with synchronous active-high reset.
 */
`timescale 1ns/1ps
module ump_aux_monitor (
   // clock, reset and configuration
   input wire logic ref_clk, reset, enh_unlock, spec_char_en, multidrop_en,
   input wire logic irda_en, loopback_en, sleep_en, wake_int_en,
   input wire logic [ump_pkg::UMP_DATA_W-1:0] second_stop_char, rx_char_data,
   // receive side
   input wire logic rx_char_valid, rx_char_parity, rx_char_ready, rxb_valid,
   input wire logic rx_enabled, force_parity_zero, line_status_int,
   // serial and modem
   input wire logic tx_shift_out, tx_pin, rx_to_core, rts_n_out, dtr_n_out,
   // power
   input wire logic int_pending, divisor_nonzero, tx_fifo_empty, rx_fifo_empty,
   input wire logic [3:0] msr_delta,
   input wire logic thr_write, bus_isolate_pin, asleep, osc_run, bus_isolated, wake_int
);
   import ump_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic auto_mode, normal_mode, addr_take, sleep_ok;
   assign auto_mode = multidrop_en && enh_unlock && spec_char_en;
   assign normal_mode = multidrop_en && enh_unlock && !spec_char_en;
   assign addr_take = rx_char_valid && rx_char_ready && rx_char_parity;
   // wake_int counts as a pending interrupt
   assign sleep_ok = !int_pending && !wake_int && sleep_en && msr_delta == 4'h0 &&
      divisor_nonzero && tx_fifo_empty && rx_fifo_empty;
   mdrop_parity_a: assert property (
      normal_mode |=> force_parity_zero) else $error("zero parity not forced");
   addr_flag_a: assert property (
      addr_take && normal_mode |=> line_status_int && rxb_valid)
      else $error("address byte not stored with interrupt");
   auto_match_a: assert property (
      addr_take && auto_mode && rx_char_data == second_stop_char
      |=> rx_enabled && rxb_valid && line_status_int) else $error("matching address lost");
   auto_drop_a: assert property (
      addr_take && auto_mode && rx_enabled && rx_char_data != second_stop_char
      |=> !rx_enabled && !line_status_int) else $error("mismatching address kept receiver on");
   sleep_guard_a: assert property (
      $rose(asleep) |-> $past(sleep_ok, 2)) else $error("sleep entered with a blocker");
   osc_stop_a: assert property (
      asleep |-> !osc_run) else $error("oscillator running while asleep");
   thr_wake_a: assert property (
      asleep && !bus_isolated && thr_write |=> !asleep) else $error("write did not wake");
   iso_pin_a: assert property (
      $rose(bus_isolated) |-> $past(bus_isolate_pin, 3)) else $error("isolated without pin");
   wint_set_a: assert property (
      $past(wake_int_en) && $past(sleep_en) && $fell(asleep) |-> ##[0:1] wake_int)
      else $error("no wake interrupt");
   wint_gate_a: assert property (
      $rose(wake_int) |-> $past(wake_int_en)) else $error("wake interrupt while disabled");
   loop_feed_a: assert property (
      loopback_en && !irda_en |=> rx_to_core == $past(tx_shift_out))
      else $error("loopback data not routed");
   loop_pins_a: assert property (
      $past(loopback_en) |-> tx_pin && rts_n_out && dtr_n_out)
      else $error("pins not parked in loopback");
   cover property ($rose(asleep));
   cover property ($rose(bus_isolated));
   cover property (rx_enabled ##1 !rx_enabled);
endmodule
bind ump_aux ump_aux_monitor u_mon (.*);

// ---- sim/ump_remote_node.sv ----
/*
 * far serial node: drives the receive line and the four modem inputs.
 * assumes bench requests are one-cycle pulses on ref_clk.
 */
`timescale 1ns/1ps
module ump_remote_node (
   // bench requests
   input wire logic ref_clk,
   input wire logic ir_mode,
   input wire logic start_req,
   input wire logic modem_req,
   // line side
   output logic rx_line,
   output logic [3:0] modem_n
);
   import ump_pkg::*;
   int cnt = 0;
   initial modem_n = UMP_MODEM_IDLE;
   // start bit: a full bit low on a wire line, a short high flash on infrared
   always @(posedge ref_clk) begin
      if (start_req) cnt <= ir_mode ? 3 : 16;
      else if (cnt != 0) cnt <= cnt - 1;
      if (modem_req) modem_n[0] <= ~modem_n[0];
   end
   assign rx_line = (cnt != 0) ? ir_mode : !ir_mode;
endmodule

// ---- sim/test_uart_multidrop_irda_sleep_loopback.sv ----
/*
 * bench for ump_aux: core-side and host-side ports driven by tasks.
 * assumes ump_pkg, ump_fifo and ump_aux are compiled first.
 */
`timescale 1ns/1ps
module test_uart_multidrop_irda_sleep_loopback;
   logic ref_clk, reset, enh_unlock, spec_char_en, multidrop_en, irda_fast_sel, irda_en;
   logic loopback_en, sleep_en, wake_int_en, rx_enable_wr, rx_enable_val, rx_char_valid;
   logic rx_char_parity, rx_char_perr, rxb_ready, baud16_tick, tx_bit_start, tx_shift_out;
   logic rts_req, dtr_req, int_pending, divisor_nonzero, tx_fifo_empty, rx_fifo_empty;
   logic thr_write, bus_isolate_pin, wake_int_clr, start_req, modem_req, rx_line;
   logic rx_char_ready, rxb_valid, rx_enabled, force_parity_zero, line_status_int, tx_pin;
   logic rx_to_core, rts_n_out, dtr_n_out, asleep, osc_run, bus_isolated, wake_int;
   logic [7:0] second_stop_char, rx_char_data;
   logic [3:0] msr_delta, modem_n, modem_to_core;
   logic [8:0] rxb_data, q[$];
   int fail_count, cmp_count, n;
   ump_aux u_dut (.*, .rx_pin(rx_line), .cts_n_in(modem_n[0]), .dsr_n_in(modem_n[1]),
      .carrier_detect_in(modem_n[2]), .ring_indicate_in(modem_n[3]));
   ump_remote_node u_node (.ref_clk, .ir_mode(irda_en), .start_req, .modem_req, .rx_line,
      .modem_n);
   initial begin
      ref_clk = 0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic step(input int k = 1);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic check_val(input logic [8:0] got, input logic [8:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      step();
      s = 0;
   endtask
   // one character from the core; checks the status pulse, queues what must be kept
   task automatic send(input logic p, input logic [7:0] d, input logic keep, input logic lsi);
      logic seen;
      int w = 0;
      while (rx_char_ready !== 1'b1 && w < 50) begin
         step();
         w++;
      end
      {rx_char_valid, rx_char_parity, rx_char_perr, rx_char_data} = {1'b1, p, !p, d};
      step();
      rx_char_valid = 0;
      seen = line_status_int;
      step();
      seen = seen | line_status_int;
      check_val({8'h00, seen}, {8'h00, lsi});
      if (keep) q.push_back({p, d});
   endtask
   task automatic drain();
      rxb_ready = 1;
      while (q.size() != 0) begin
         check_val({8'h00, rxb_valid}, 9'h001);
         check_val(rxb_data, q.pop_front());
         step();
      end
      rxb_ready = 0;
      check_val({8'h00, rxb_valid}, 9'h000);
   endtask
   task automatic host_rx_en(input logic v);
      rx_enable_val = v;
      pulse(rx_enable_wr);
      step();
   endtask
   task automatic finish_test();
      $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // the whole sequence needs well under a thousand cycles
   initial begin
      #500000;
      fail_count++;
      finish_test();
   end
   initial begin
      {enh_unlock, spec_char_en, multidrop_en, irda_fast_sel, irda_en, loopback_en} = '0;
      {sleep_en, wake_int_en, rx_enable_wr, rx_enable_val, rx_char_valid, rx_char_parity} = '0;
      {rx_char_perr, rxb_ready, baud16_tick, tx_bit_start, tx_shift_out, rts_req} = 6'h02;
      {dtr_req, int_pending, thr_write, bus_isolate_pin, wake_int_clr, start_req} = '0;
      {modem_req, divisor_nonzero, tx_fifo_empty, rx_fifo_empty} = 4'h7;
      {rx_char_data, second_stop_char, msr_delta} = {8'h00, 8'h5A, 4'h0};
      {fail_count, cmp_count} = '0;
      reset = 1;
      step(16);
      reset = 0;
      step(2);
      check_val({tx_pin, rx_to_core, rts_n_out, dtr_n_out, asleep, osc_run, bus_isolated,
         wake_int, rx_enabled}, 9'h1E8);
      {enh_unlock, multidrop_en} = 2'b11;
      step();
      check_val({8'h00, force_parity_zero}, 9'h001);
      send(0, 8'h11, 0, 0);
      send(1, 8'h21, 1, 1);
      host_rx_en(1);
      send(0, 8'h33, 1, 0);
      send(1, 8'h42, 1, 1);
      drain();
      n = 0;
      while (rx_char_ready === 1'b1 && n < 8) begin
         send(0, 8'h80 + n[7:0], 1, 0);
         n++;
      end
      check_val({8'h00, rx_char_ready}, 9'h000);
      drain();
      spec_char_en = 1;
      host_rx_en(0);
      send(0, 8'h5A, 0, 0);
      send(1, 8'h33, 0, 0);
      send(1, 8'h5A, 1, 1);
      check_val({8'h00, rx_enabled}, 9'h001);
      send(0, 8'h66, 1, 0);
      send(1, 8'h5A, 1, 1);
      send(1, 8'h77, 0, 0);
      check_val({8'h00, rx_enabled}, 9'h000);
      drain();
      {spec_char_en, multidrop_en, rts_req, dtr_req} = 4'h3;
      step(2);
      check_val({7'h00, rts_n_out, dtr_n_out}, 9'h000);
      loopback_en = 1;
      for (int i = 0; i < 4; i++) begin
         tx_shift_out = i[0];
         step();
         check_val({7'h00, rx_to_core, tx_pin}, {7'h00, i[0], 1'b1});
      end
      check_val({7'h00, rts_n_out, dtr_n_out}, 9'h003);
      pulse(modem_req);
      step(4);
      check_val({5'h00, modem_to_core}, 9'h00F);
      {loopback_en, irda_en, baud16_tick} = 3'b011;
      step(8);
      check_val({8'h00, rx_to_core}, 9'h001);
      check_val({5'h00, modem_to_core}, 9'h00E);
      for (int f = 0; f < 2; f++) begin
         {irda_fast_sel, tx_shift_out} = {f[0], 1'b0};
         pulse(tx_bit_start);
         n = 0;
         repeat (12) begin
            if (tx_pin === 1'b1) n++;
            step();
         end
         check_val(n[8:0], f ? 9'h004 : 9'h003);
      end
      pulse(start_req);
      step(5);
      check_val({8'h00, rx_to_core}, 9'h000);
      step(20);
      {irda_en, baud16_tick, tx_shift_out, sleep_en, wake_int_en} = 5'h07;
      step(6);
      check_val({7'h00, asleep, osc_run}, 9'h002);
      pulse(thr_write);
      step(2);
      check_val({7'h00, asleep, wake_int}, 9'h001);
      pulse(wake_int_clr);
      step(4);
      check_val({7'h00, asleep, wake_int}, 9'h002);
      bus_isolate_pin = 1;
      step(4);
      check_val({7'h00, asleep, bus_isolated}, 9'h003);
      pulse(thr_write);
      step(2);
      check_val({7'h00, asleep, bus_isolated}, 9'h003);
      pulse(start_req);
      step(6);
      check_val({7'h00, asleep, wake_int}, 9'h001);
      step(20);
      pulse(wake_int_clr);
      step(4);
      check_val({7'h00, asleep, bus_isolated}, 9'h003);
      pulse(modem_req);
      msr_delta = 4'h1;
      step(4);
      check_val({7'h00, asleep, wake_int}, 9'h001);
      msr_delta = 4'h0;
      pulse(wake_int_clr);
      step(4);
      check_val({7'h00, asleep, bus_isolated}, 9'h003);
      sleep_en = 0;
      step(3);
      check_val({7'h00, asleep, bus_isolated}, 9'h000);
      {int_pending, sleep_en} = 2'b11;
      pulse(wake_int_clr);
      step(4);
      check_val({8'h00, asleep}, 9'h000);
      finish_test();
   end
endmodule
